//--- inc/edge_timing_pkg.sv
// constants for the charge-time edge control block
package edge_timing_pkg;
   localparam int          DATA_W            = 32;
   localparam int          ADDR_W            = 12;
   localparam logic [11:0] CONTROL_ADDR      = 12'h000;
   localparam logic [11:0] IRQ_STATUS_ADDR   = 12'h004;
   localparam logic [11:0] IRQ_ENABLE_ADDR   = 12'h008;
   localparam logic [11:0] IRQ_CLEAR_ADDR    = 12'h00C;
   localparam int          UNIT_ENABLE_BIT   = 15;
   localparam int          UNUSED_BIT        = 14;
   localparam int          IDLE_STOP_BIT     = 13;
   localparam int          DELAY_GEN_BIT     = 12;
   localparam int          EDGE_PASS_BIT     = 11;
   localparam int          EDGE_ORDER_BIT    = 10;
   localparam int          GROUND_BIT        = 9;
   localparam int          TRIGGER_BIT       = 8;
   localparam int          SECOND_POL_BIT    = 7;
   localparam int          SECOND_SRC_LSB    = 5;
   localparam int          FIRST_POL_BIT     = 4;
   localparam int          FIRST_SRC_LSB     = 2;
   localparam int          SECOND_SEEN_BIT   = 1;
   localparam int          FIRST_SEEN_BIT    = 0;
   localparam logic [15:0] CONTROL_RESET     = 16'h0000;
   localparam logic [15:0] CONTROL_WMASK     = 16'hBFFF;
   localparam int          IRQ_W             = 3;
   localparam int          IRQ_FIRST         = 0;
   localparam int          IRQ_SECOND        = 1;
   localparam int          IRQ_PULSE         = 2;
   localparam int          SYNC_STAGES       = 2;
   localparam int          SRC_COUNT         = 4;
   localparam logic [1:0]  SRC_TIMER         = 2'h0;
   localparam logic [1:0]  SRC_COMPARE       = 2'h1;
   localparam logic [1:0]  SRC_PIN_TWO       = 2'h2;
   localparam logic [1:0]  SRC_PIN_ONE       = 2'h3;
endpackage

//--- src/charge_time_edge_control.sv
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// edge sequencing and control of the charge-time measurement unit
module charge_time_edge_control
   import edge_timing_pkg::*;
(
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [edge_timing_pkg::ADDR_W-1:0] paddr,
   input  wire logic [edge_timing_pkg::DATA_W-1:0] pwdata,
   output logic      [edge_timing_pkg::DATA_W-1:0] prdata,
   output logic                                pready,
   output logic                                pslverr,
   input  wire logic                           cpu_idle,
   input  wire logic                           ext_edge_pin_one,
   input  wire logic                           ext_edge_pin_two,
   input  wire logic                           output_compare_one,
   input  wire logic                           timer_one_event,
   input  wire logic                           comparator_trip,
   output logic                                unit_active,
   output logic                                current_source_on,
   output logic                                source_grounded,
   output logic                                source_to_cmp_two_b,
   output logic                                measure_pulse,
   output logic                                delayed_pulse_out,
   output logic                                trigger_out,
   output logic                                irq
);
   import edge_timing_pkg::*;

   localparam int SYNC_W = SRC_COUNT + 1;

   logic [15:0]       control;
   logic [IRQ_W-1:0]  irq_status;
   logic [IRQ_W-1:0]  irq_enable;
   logic              first_seen;
   logic              second_seen;
   logic              pulse_q;
   logic              charging;
   logic [SYNC_W-1:0] src_now;
   logic [SYNC_W-1:0] src_prev;

   // source index follows the select encoding; comparator sits on top
   wire [SYNC_W-1:0] raw_sources;
   assign raw_sources[SRC_TIMER]   = timer_one_event;
   assign raw_sources[SRC_COMPARE] = output_compare_one;
   assign raw_sources[SRC_PIN_TWO] = ext_edge_pin_two;
   assign raw_sources[SRC_PIN_ONE] = ext_edge_pin_one;
   assign raw_sources[SRC_COUNT]   = comparator_trip;

   edge_sync #(.WIDTH(SYNC_W)) u_sync
   (
      .pclk      (pclk),
      .presetn   (presetn),
      .async_in  (raw_sources),
      .sync_out  (src_now),
      .sync_prev (src_prev)
   );

   function automatic logic edge_hit(input logic [1:0] sel,
                                     input logic       rising,
                                     input logic [SYNC_W-1:0] now,
                                     input logic [SYNC_W-1:0] prev);
      logic n;
      logic p;
      n = now[sel];
      p = prev[sel];
      edge_hit = rising ? (n & ~p) : (~n & p);
   endfunction

   wire        wr_en      = psel & penable & pwrite;
   wire        ctl_sel    = (paddr == CONTROL_ADDR);
   wire        sts_sel    = (paddr == IRQ_STATUS_ADDR);
   wire        ena_sel    = (paddr == IRQ_ENABLE_ADDR);
   wire        clr_sel    = (paddr == IRQ_CLEAR_ADDR);
   wire        mapped     = ctl_sel | sts_sel | ena_sel | clr_sel;
   wire        ctl_wr     = wr_en & ctl_sel;

   wire        unit_en    = control[UNIT_ENABLE_BIT];
   wire        idle_halt  = control[IDLE_STOP_BIT] & cpu_idle;
   wire        running    = unit_en & ~idle_halt;
   wire        delay_mode = control[DELAY_GEN_BIT];
   wire        edges_open = running & control[EDGE_PASS_BIT];
   wire        order_on   = control[EDGE_ORDER_BIT];
   wire        grounded   = control[GROUND_BIT];
   wire [1:0]  first_src  = control[FIRST_SRC_LSB +: 2];
   wire [1:0]  second_src = control[SECOND_SRC_LSB +: 2];
   wire        first_raw  = edge_hit(first_src,
                               control[FIRST_POL_BIT],
                               src_now, src_prev);
   wire        second_raw = edge_hit(second_src,
                               control[SECOND_POL_BIT],
                               src_now, src_prev);
   wire        first_evt  = edges_open & first_raw;
   wire        second_evt = edges_open & second_raw
                            & (~order_on | first_seen);
   wire        cmp_rise   = src_now[SRC_COUNT] & ~src_prev[SRC_COUNT];
   wire        trip_evt   = running & delay_mode & charging & cmp_rise;

   // status bits written by software may clear; a new event wins
   wire wr_first  = ctl_wr & ~pwdata[FIRST_SEEN_BIT];
   wire wr_second = ctl_wr & ~pwdata[SECOND_SEEN_BIT];
   wire next_first_seen  = first_evt | (first_seen & ~wr_first);
   wire next_second_seen = second_evt | (second_seen & ~wr_second);

   wire [IRQ_W-1:0] irq_events;
   assign irq_events[IRQ_FIRST]  = first_evt;
   assign irq_events[IRQ_SECOND] = second_evt;
   assign irq_events[IRQ_PULSE]  = trip_evt;
   wire [IRQ_W-1:0] irq_clr = (wr_en & clr_sel) ? pwdata[IRQ_W-1:0]
                                                : '0;

   wire [15:0] control_view = {control[15:2], second_seen, first_seen};

   // control register; bit 14 never stores
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         control <= CONTROL_RESET;
      end
      else if (ctl_wr)
      begin
         control <= pwdata[15:0] & CONTROL_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         first_seen <= 1'b0;
      end
      else
      begin
         first_seen <= next_first_seen;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         second_seen <= 1'b0;
      end
      else
      begin
         second_seen <= next_second_seen;
      end
   end

   // delay generation: charge from edge until comparator trips
   wire delay_live    = running & delay_mode;
   wire next_charging = delay_live & ~trip_evt & (charging | first_evt);
   wire next_pulse_q  = delay_live & (trip_evt | (pulse_q & ~first_evt));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         charging <= 1'b0;
      end
      else
      begin
         charging <= next_charging;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pulse_q <= 1'b0;
      end
      else
      begin
         pulse_q <= next_pulse_q;
      end
   end

   wire [IRQ_W-1:0] next_irq_status = irq_events | (irq_status & ~irq_clr);
   wire             ena_wr          = wr_en & ena_sel;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status <= '0;
      end
      else
      begin
         irq_status <= next_irq_status;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_enable <= '0;
      end
      else if (ena_wr)
      begin
         irq_enable <= pwdata[IRQ_W-1:0];
      end
   end

   function automatic logic [DATA_W-1:0] irq_word(
      input logic [IRQ_W-1:0] bits);
      irq_word = {{(DATA_W-IRQ_W){1'b0}}, bits};
   endfunction

   // read data loaded in the setup cycle, standing through access
   wire              rd_setup  = psel & ~penable & ~pwrite;
   wire [DATA_W-1:0] read_word = ctl_sel ? {16'h0000, control_view}
                               : sts_sel ? irq_word(irq_status)
                               : ena_sel ? irq_word(irq_enable)
                               : '0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= '0;
      end
      else if (rd_setup)
      begin
         prdata <= read_word;
      end
   end

   // analog controls; outputs held low while unit enable is clear; idle stop leaves grounding and comparator routing on
   wire charge_window          = running & first_seen & ~second_seen;
   wire next_source_grounded   = unit_en & grounded;
   wire next_current_source_on = ~grounded
                                 & (delay_mode ? charging : charge_window);
   wire next_source_to_cmp_b   = unit_en & delay_mode;
   wire next_measure_pulse     = ~delay_mode & charge_window;
   wire next_trigger_out       = running & control[TRIGGER_BIT]
                                 & (first_evt | second_evt);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unit_active <= 1'b0;
      end
      else
      begin
         unit_active <= running;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         current_source_on <= 1'b0;
      end
      else
      begin
         current_source_on <= next_current_source_on;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         source_grounded <= 1'b0;
      end
      else
      begin
         source_grounded <= next_source_grounded;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         source_to_cmp_two_b <= 1'b0;
      end
      else
      begin
         source_to_cmp_two_b <= next_source_to_cmp_b;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         measure_pulse <= 1'b0;
      end
      else
      begin
         measure_pulse <= next_measure_pulse;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         delayed_pulse_out <= 1'b0;
      end
      else
      begin
         delayed_pulse_out <= pulse_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         trigger_out <= 1'b0;
      end
      else
      begin
         trigger_out <= next_trigger_out;
      end
   end

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign irq     = |(irq_status & irq_enable);
endmodule // charge_time_edge_control

//--- src/edge_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser bank with a registered previous value
module edge_sync
#(
   parameter int WIDTH = 5
)
(
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out,
   output logic      [WIDTH-1:0] sync_prev
);
   logic [WIDTH-1:0] stage_one;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage_one <= '0;
         sync_out  <= '0;
         sync_prev <= '0;
      end
      else
      begin
         stage_one <= async_in;
         sync_out  <= stage_one;
         sync_prev <= sync_out;
      end
   end
endmodule // edge_sync

//--- verification/edge_ctl_chk.sv
// port assertions for the charge-time edge control block
`timescale 1ns/1ps
module edge_ctl_chk
   import edge_timing_pkg::*;
(
   input wire logic                           pclk,
   input wire logic                           presetn,
   input wire logic                           cpu_idle,
   input wire logic                           comparator_trip,
   input wire logic                           unit_active,
   input wire logic                           current_source_on,
   input wire logic                           source_grounded,
   input wire logic                           source_to_cmp_two_b,
   input wire logic                           measure_pulse,
   input wire logic                           delayed_pulse_out,
   input wire logic                           trigger_out
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_off;
      !unit_active && !$past(cpu_idle) |-> !source_grounded;
   endproperty
   a_off: assert property (p_off) else $error("grounded while off");
   property p_route;
      measure_pulse |-> !source_to_cmp_two_b;
   endproperty
   a_route: assert property (p_route) else $error("pulse in delay mode");
   property p_cur;
      current_source_on |-> !source_grounded;
   endproperty
   a_cur: assert property (p_cur) else $error("charging while grounded");
   property p_trig;
      trigger_out |-> unit_active;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger while off");
   property p_trig1;
      trigger_out |=> !trigger_out;
   endproperty
   a_trig1: assert property (p_trig1) else $error("trigger too long");
   property p_meas;
      $fell(unit_active) |=> !measure_pulse;
   endproperty
   a_meas: assert property (p_meas) else $error("pulse after stop");
   property p_dly;
      $rose(delayed_pulse_out) |-> $past(comparator_trip, 3)
         && $past(source_to_cmp_two_b);
   endproperty
   a_dly: assert property (p_dly) else $error("early delayed pulse");
   property p_cdly;
      $rose(measure_pulse) && !source_grounded |-> current_source_on;
   endproperty
   a_cdly: assert property (p_cdly) else $error("source not on");
endmodule // edge_ctl_chk

bind charge_time_edge_control edge_ctl_chk u_chk (.pclk(pclk),
   .presetn(presetn), .cpu_idle(cpu_idle),
   .comparator_trip(comparator_trip), .unit_active(unit_active),
   .current_source_on(current_source_on),
   .source_grounded(source_grounded),
   .source_to_cmp_two_b(source_to_cmp_two_b),
   .measure_pulse(measure_pulse), .delayed_pulse_out(delayed_pulse_out),
   .trigger_out(trigger_out));

//--- verification/edge_src_model.sv
// edge sources and comparator outside the block
`timescale 1ns/1ps
module edge_src_model
(
   input  wire logic       pclk,
   input  wire logic [3:0] lvl_req,
   input  wire logic       trip_req,
   output logic      [3:0] lvl,
   output logic            trip
);
   // levels move just after the clock edge
   always_ff @(posedge pclk)
   begin
      lvl  <= lvl_req;
      trip <= trip_req;
   end
endmodule // edge_src_model

//--- verification/testbench.sv
// self-checking bench for the charge-time edge control block
`timescale 1ns/1ps
module testbench;
   import edge_timing_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, cpu_idle, trip_req;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, err, unit_active, current_source_on;
   logic        source_grounded, source_to_cmp_two_b, measure_pulse;
   logic        delayed_pulse_out, trigger_out, irq, trip;
   logic [3:0]  lvl_req, lvl;
   int          bad_count, checks;
   charge_time_edge_control dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_idle,
      .ext_edge_pin_one(lvl[3]), .ext_edge_pin_two(lvl[2]),
      .output_compare_one(lvl[1]), .timer_one_event(lvl[0]),
      .comparator_trip(trip), .unit_active, .current_source_on,
      .source_grounded, .source_to_cmp_two_b, .measure_pulse,
      .delayed_pulse_out, .trigger_out, .irq);
   edge_src_model far (.pclk, .lvl_req, .trip_req, .lvl, .trip);
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic results();
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic t_regs();
      apb(0, CONTROL_ADDR, 0);
      chk(rd, 32'h0000_0000);
      apb(1, CONTROL_ADDR, 32'h0000_FFFF);
      apb(0, CONTROL_ADDR, 0);
      chk(rd, 32'h0000_BFFC);
      apb(1, CONTROL_ADDR, 0);
      apb(0, 12'h010, 0);
      chk({rd[30:0], err}, 32'h0000_0001);
      $display("t_regs done");
   endtask
   task automatic t_measure();
      apb(1, CONTROL_ADDR, 32'h0000_8DDC);
      apb(1, IRQ_ENABLE_ADDR, 32'h0000_0003);
      lvl_req <= 4'h4;
      cyc(8);
      apb(0, CONTROL_ADDR, 0);
      chk(rd[1:0], 2'h0);
      lvl_req <= 4'hC;
      cyc(5);
      chk(trigger_out, 1'b1);
      cyc(3);
      chk({measure_pulse, current_source_on, irq}, 3'h7);
      lvl_req <= 4'h8;
      cyc(4);
      lvl_req <= 4'hC;
      cyc(8);
      chk({measure_pulse, current_source_on}, 2'h0);
      apb(0, CONTROL_ADDR, 0);
      chk(rd, 32'h0000_8DDF);
      apb(1, IRQ_CLEAR_ADDR, 32'h0000_0003);
      chk(irq, 1'b0);
      apb(1, CONTROL_ADDR, 32'h0000_801C);
      lvl_req <= 4'h0;
      cyc(4);
      lvl_req <= 4'h8;
      cyc(8);
      apb(0, CONTROL_ADDR, 0);
      chk(rd[1:0], 2'h0);
      apb(1, CONTROL_ADDR, 0);
      lvl_req <= 4'h0;
      $display("t_measure done");
   endtask
   task automatic t_sources();
      logic [31:0] w;
      for (int s = 0; s < 4; s++)
      begin
         w = 32'h0000_8800 | (s << 5) | (s << 2);
         lvl_req <= 4'hF;
         cyc(4);
         apb(1, CONTROL_ADDR, w);
         lvl_req[s] <= 1'b0;
         cyc(5);
         chk(trigger_out, 1'b0);
         cyc(3);
         apb(0, CONTROL_ADDR, 0);
         chk(rd[1:0], 2'h3);
         apb(1, CONTROL_ADDR, w);
         lvl_req[s] <= 1'b1;
         cyc(8);
         apb(0, CONTROL_ADDR, 0);
         chk(rd[1:0], 2'h0);
         apb(1, CONTROL_ADDR, 0);
      end
      lvl_req <= 4'h0;
      $display("t_sources done");
   endtask
   task automatic t_delay();
      apb(1, CONTROL_ADDR, 32'h0000_9810);
      cyc(1);
      chk(source_to_cmp_two_b, 1'b1);
      lvl_req <= 4'h1;
      cyc(8);
      chk({current_source_on, delayed_pulse_out}, 2'h2);
      trip_req <= 1'b1;
      cyc(8);
      chk(delayed_pulse_out, 1'b1);
      apb(0, IRQ_STATUS_ADDR, 0);
      chk(rd[2], 1'b1);
      apb(1, CONTROL_ADDR, 0);
      apb(1, IRQ_CLEAR_ADDR, 32'h0000_0007);
      trip_req <= 1'b0;
      lvl_req <= 4'h0;
      $display("t_delay done");
   endtask
   task automatic t_idle();
      apb(1, CONTROL_ADDR, 32'h0000_A000);
      cyc(1);
      chk(unit_active, 1'b1);
      cpu_idle <= 1'b1;
      cyc(3);
      chk(unit_active, 1'b0);
      apb(1, CONTROL_ADDR, 32'h0000_8200);
      cyc(2);
      chk({unit_active, source_grounded}, 2'h3);
      cpu_idle <= 1'b0;
      apb(1, CONTROL_ADDR, 0);
      cyc(2);
      chk({unit_active, source_grounded}, 2'h0);
      $display("t_idle done");
   endtask
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      cpu_idle = 1'b0;
      trip_req = 1'b0;
      lvl_req = 4'h0;
      bad_count = 0;
      checks = 0;
      cyc(2);
      presetn <= 1'b1;
      cyc(1);
      t_regs();
      t_measure();
      t_sources();
      t_delay();
      t_idle();
      results();
   end
   initial
   begin
      #20000;
      bad_count++;
      results();
   end
endmodule // testbench
